// *** verification/remote_calibration_and_reset_tb.sv ***
// Self-checking bench for the calibration and general-call reset block.
`timescale 1ns/100ps
module remote_calibration_and_reset_tb;
  import cal_pkg::*;
  logic i_clk, i_link_clk, i_reset_n;
  logic [11:0] i_remote_raw, o_remote_result;
  logic o_scl_oe, o_sda_oe, h_scl_low, h_sda_low, h_timeout;
  logic o_result_valid, o_conv_busy, o_soft_reset;
  logic [7:0] rd;
  logic [2:0] acks;
  int n_errors, n_compared, n_soft;
  wire scl;
  wire sda;

  // Pull-ups: a line is low whenever any party pulls it.
  assign scl = ~(h_scl_low | o_scl_oe);
  assign sda = ~(h_sda_low | o_sda_oe);

  remote_calibration_and_reset i_remote_calibration_and_reset (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_link_clk(i_link_clk), .i_scl(scl), .o_scl(), .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda(),
    .o_sda_oe(o_sda_oe), .i_remote_raw(i_remote_raw), .o_remote_result(o_remote_result),
    .o_result_valid(o_result_valid), .o_conv_busy(o_conv_busy), .o_soft_reset(o_soft_reset));
  twowire_host i_twowire_host (.i_clk(i_clk), .i_scl(scl), .i_sda(sda), .o_scl_low(h_scl_low),
    .o_sda_low(h_sda_low), .o_timeout(h_timeout));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #7.3;
    forever #16 i_link_clk = ~i_link_clk;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [11:0] expect_result(input logic [11:0] raw, input logic [7:0] adj, input logic [7:0] off);
    int v;
    v = int'(raw) * (2088 + int'($signed(adj))) / 2088 + int'($signed(off)) * 16;
    if (v < 0) v = 0;
    if (v > 4095) v = 4095;
    return 12'(v);
  endfunction

  // The first result may still come from the previous input, so the second is judged.
  task automatic conv_check(input logic [11:0] raw, input logic [7:0] adj, input logic [7:0] off);
    int k;
    i_remote_raw <= raw;
    k = 0;
    for (int c = 0; c < 2; c++) begin
      k = 0;
      @(posedge i_clk);
      while (o_result_valid !== 1'b1 && k < 1200) begin
        @(posedge i_clk);
        k++;
      end
    end
    if (k >= 1200) begin
      n_errors++;
      test_done();
    end else begin
      check("remote result", expect_result(raw, adj, off), o_remote_result);
    end
  endtask

  always @(posedge i_clk) begin
    if (o_soft_reset === 1'b1) begin
      n_soft++;
      check("busy at soft reset", 12'h000, {11'h000, o_conv_busy});
      check("result at soft reset", RESULT_RESET, o_remote_result);
    end
    if (h_timeout === 1'b1) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    #400000;
    n_errors++;
    test_done();
  end

  initial begin
    i_reset_n = 1'b0;
    i_remote_raw = 12'h7d0;
    n_errors = 0;
    n_compared = 0;
    n_soft = 0;
    // Reset spans cycles of the slower link clock so that both domains see it.
    repeat (3) @(posedge i_link_clk);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (10) @(posedge i_link_clk);
    @(posedge i_clk);
    i_twowire_host.read_reg(ADJ_PTR, rd, acks);
    check("adjust power-on", ADJ_RESET, rd);
    check("read acks", 3'b111, acks);
    i_twowire_host.read_reg(ID_PTR, rd, acks);
    check("maker id", MAKER_ID, rd);
    conv_check(12'h7d0, 8'h00, 8'h00);
    $display("test power_on done");
    i_twowire_host.write_reg(ADJ_PTR, 8'h85, acks);
    i_twowire_host.read_reg(ADJ_PTR, rd, acks);
    check("adjust readback", 8'h85, rd);
    conv_check(12'h7d0, 8'h85, 8'h00);
    conv_check(12'hfff, 8'h85, 8'h00);
    i_twowire_host.write_reg(OFFSET_PTR, 8'hfe, acks);
    conv_check(12'h7d0, 8'h85, 8'hfe);
    $display("test calibration done");
    i_twowire_host.write_reg(ID_PTR, 8'h11, acks);
    check("id write acks", 3'b111, acks);
    i_twowire_host.read_reg(ID_PTR, rd, acks);
    check("maker id after write", MAKER_ID, rd);
    $display("test id_write done");
    i_twowire_host.gcall(8'h05, acks[1:0]);
    check("general call acks", 12'h003, {10'h000, acks[1:0]});
    check("soft resets", 12'h000, 12'(n_soft));
    conv_check(12'h7d0, 8'h85, 8'hfe);
    i_twowire_host.gcall(GC_RESET_CMD, acks[1:0]);
    check("soft resets", 12'h001, 12'(n_soft));
    i_twowire_host.read_reg(ADJ_PTR, rd, acks);
    check("adjust after reset", ADJ_RESET, rd);
    conv_check(12'h7d0, 8'h00, 8'h00);
    $display("test general_call done");
    i_twowire_host.write_reg(OFFSET_PTR, 8'hfe, acks);
    conv_check(12'h800, 8'h00, 8'hfe);
    i_twowire_host.write_reg(ADJ_PTR, 8'h7f, acks);
    conv_check(12'h7d0, 8'h7f, 8'hfe);
    $display("test offset_gain done");
    test_done();
  end
endmodule

// *** verification/twowire_host.sv ***
// Two-wire bus controller model that drives the block's bus pins.
`timescale 1ns/100ps
module twowire_host
  import cal_pkg::*;
#(
  parameter logic [6:0] ADDR = DEV_ADDR_DEFAULT,
  parameter int Q = 48
) (
  // Clock
  input wire logic i_clk,
  // Resolved bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Pull-down requests and hang flag
  output logic o_scl_low,
  output logic o_sda_low,
  output logic o_timeout
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_timeout = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // The device may hold SCL low, so the high phase starts only once the wire is seen high.
  task automatic clk_high();
    int k;
    o_scl_low <= 1'b0;
    k = 0;
    @(posedge i_clk);
    while (i_scl !== 1'b1 && k < 5000) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 5000) o_timeout <= 1'b1;
    tick(2 * Q);
  endtask

  task automatic put_bit(input logic b);
    o_sda_low <= ~b;
    tick(Q);
    clk_high();
    o_scl_low <= 1'b1;
    tick(Q);
  endtask

  task automatic get_bit(output logic b);
    o_sda_low <= 1'b0;
    tick(Q);
    clk_high();
    b = i_sda;
    o_scl_low <= 1'b1;
    tick(Q);
  endtask

  // Serves as a plain and as a repeated start.
  task automatic start();
    o_sda_low <= 1'b0;
    tick(Q);
    clk_high();
    o_sda_low <= 1'b1;
    tick(2 * Q);
    o_scl_low <= 1'b1;
    tick(Q);
  endtask

  task automatic stop();
    o_sda_low <= 1'b1;
    tick(Q);
    clk_high();
    o_sda_low <= 1'b0;
    tick(4 * Q);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask

  task automatic recv(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(last);
  endtask

  task automatic write_reg(input logic [7:0] p, input logic [7:0] v, output logic [2:0] acks);
    start();
    send({ADDR, 1'b0}, acks[2]);
    send(p, acks[1]);
    send(v, acks[0]);
    stop();
  endtask

  task automatic read_reg(input logic [7:0] p, output logic [7:0] v, output logic [2:0] acks);
    start();
    send({ADDR, 1'b0}, acks[2]);
    send(p, acks[1]);
    start();
    send({ADDR, 1'b1}, acks[0]);
    recv(1'b1, v);
    stop();
  endtask

  task automatic gcall(input logic [7:0] cmd, output logic [1:0] acks);
    start();
    send({GC_ADDR, 1'b0}, acks[1]);
    send(cmd, acks[0]);
    stop();
  endtask
endmodule

// *** verilog/cal_pkg.sv ***
// Shared constants and types for the remote calibration and reset block.
package cal_pkg;
  // ==========================================================================
  // Pointer map
  localparam logic [7:0] ADJ_PTR = 8'h23;
  localparam logic [7:0] OFFSET_PTR = 8'h30;
  localparam logic [7:0] ID_PTR = 8'hfe;

  // ==========================================================================
  // Power-on values and identity
  localparam logic [7:0] ADJ_RESET = 8'h00;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // The identification value is arbitrary.
  localparam logic [7:0] MAKER_ID = 8'h3c;
  // The default bus address is arbitrary.
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  // ==========================================================================
  // Two-wire protocol
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ==========================================================================
  // Conversion arithmetic and timing
  localparam int RESULT_W = 12;
  localparam int FRAC_BITS = 4;
  localparam logic [11:0] NI_BASE = 12'h828;
  localparam logic [11:0] RESULT_MAX = 12'hfff;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_CNT_W = 10;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

  typedef enum logic [1:0] {REQ_PTR, REQ_WRITE, REQ_READ, REQ_GCRESET} req_kind_e;
endpackage

// *** verilog/remote_calibration_and_reset.sv ***
// Calibration registers, remote conversion path and general-call reset.
//
// Summary of operation
// - The adjustment register is written and read at pointer 23h.
// - The adjustment is an 8-bit twos-complement value from -128 to 127.
// - After power-on the adjustment holds 00h, leaving conversions unaltered.
// - Remote result scales by 2088 plus adjustment over 2088.
// - The offset register value, times 16, is added to each remote result before it is clamped to 000h-FFFh.
// - The general call address 00h is acknowledged and its second byte checked.
// - Second byte 06h returns every register to its power-on value.
// - A general-call reset aborts the conversion in progress.
// - Any other second byte after a general call does nothing.
// - Reading pointer FEh returns the fixed maker identification code.
`timescale 1ns/100ps
module remote_calibration_and_reset
  import cal_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // Core clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Link clock
  input wire logic i_link_clk,
  // Two-wire bus pins
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Remote channel
  input wire logic [11:0] i_remote_raw,
  output logic [11:0] o_remote_result,
  output logic o_result_valid,
  output logic o_conv_busy,
  // Housekeeping
  output logic o_soft_reset
);
  typedef enum logic {CV_IDLE, CV_RUN} conv_e;

  // ==========================================================================
  // Link-side engine
  logic req_toggle, ack_toggle;
  req_kind_e req_kind;
  logic [7:0] req_data, rd_data;

  twowire_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .i_link_clk(i_link_clk),
    .i_reset_n(i_reset_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_scl_oe(o_scl_oe),
    .o_sda_oe(o_sda_oe),
    .o_req_toggle(req_toggle),
    .o_req_kind(req_kind),
    .o_req_data(req_data),
    .i_ack_toggle(ack_toggle),
    .i_rd_data(rd_data)
  );

  // Open-drain pins only ever pull low.
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;

  // ==========================================================================
  // Request crossing
  // The payload is held by the link side until the acknowledge returns, so it
  // is stable whenever the synchronised toggle reports a new request.
  logic req_s1, req_s2, req_d, req_event;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {req_s1, req_s2, req_d} <= 3'h0;
    end else begin
      {req_s1, req_s2, req_d} <= {req_toggle, req_s1, req_s2};
    end
  end

  assign req_event = req_s2 ^ req_d;

  function automatic logic [7:0] read_mux(input logic [7:0] ptr, input logic [7:0] adj_v,
                                          input logic [7:0] off_v);
    if (ptr == ADJ_PTR) begin
      read_mux = adj_v;
    end else if (ptr == OFFSET_PTR) begin
      read_mux = off_v;
    end else if (ptr == ID_PTR) begin
      read_mux = MAKER_ID;
    end else begin
      read_mux = UNMAPPED_READ;
    end
  endfunction

  // ==========================================================================
  // Register file
  logic [7:0] pointer, next_pointer, adj, next_adj, offset, next_offset, next_rd_data;
  logic next_ack_toggle, soft_reset, next_soft_reset;

  always_comb begin
    next_pointer = pointer;
    next_adj = adj;
    next_offset = offset;
    next_rd_data = rd_data;
    next_ack_toggle = ack_toggle;
    next_soft_reset = 1'b0;
    if (req_event) begin
      next_ack_toggle = ~ack_toggle;
      case (req_kind)
        REQ_PTR: begin
          next_pointer = req_data;
        end
        REQ_WRITE: begin
          if (pointer == ADJ_PTR) begin
            next_adj = req_data;
          end else if (pointer == OFFSET_PTR) begin
            next_offset = req_data;
          end
        end
        REQ_READ: begin
          next_rd_data = read_mux(pointer, adj, offset);
        end
        REQ_GCRESET: begin
          next_pointer = PTR_RESET;
          next_adj = ADJ_RESET;
          next_offset = OFFSET_RESET;
          next_rd_data = UNMAPPED_READ;
          next_soft_reset = 1'b1;
        end
        default: begin
          next_pointer = pointer;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pointer <= PTR_RESET;
      adj <= ADJ_RESET;
      offset <= OFFSET_RESET;
      rd_data <= UNMAPPED_READ;
      ack_toggle <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      pointer <= next_pointer;
      adj <= next_adj;
      offset <= next_offset;
      rd_data <= next_rd_data;
      ack_toggle <= next_ack_toggle;
      soft_reset <= next_soft_reset;
    end
  end

  assign o_soft_reset = soft_reset;

  // ==========================================================================
  // Remote result arithmetic
  // Dividing by a constant keeps this combinational; the cost is a wide
  // divider, acceptable because results only land once per conversion.
  logic [12:0] factor;
  logic [24:0] product, scaled;
  logic signed [14:0] sum;
  logic [11:0] corrected;

  always_comb begin
    factor = {1'b0, NI_BASE} + {{5{adj[7]}}, adj};
    product = 25'(i_remote_raw) * 25'(factor);
    scaled = product / 25'(NI_BASE);
    sum = $signed({2'b00, scaled[12:0]}) + $signed({{3{offset[7]}}, offset, {FRAC_BITS{1'b0}}});
    if (sum < 0) begin
      corrected = RESULT_RESET;
    end else if (sum > $signed({3'b000, RESULT_MAX})) begin
      corrected = RESULT_MAX;
    end else begin
      corrected = sum[RESULT_W-1:0];
    end
  end

  // ==========================================================================
  // Conversion sequencer
  conv_e conv_state, next_conv_state;
  logic [CONV_CNT_W-1:0] conv_cnt, next_conv_cnt;
  logic [11:0] result, next_result;
  logic valid, next_valid;

  always_comb begin
    next_conv_state = conv_state;
    next_conv_cnt = conv_cnt;
    next_result = result;
    next_valid = 1'b0;
    if (req_event && req_kind == REQ_GCRESET) begin
      next_conv_state = CV_IDLE;
      next_conv_cnt = '0;
      next_result = RESULT_RESET;
    end else begin
      case (conv_state)
        CV_IDLE: begin
          next_conv_state = CV_RUN;
          next_conv_cnt = CONV_LAST;
        end
        CV_RUN: begin
          if (conv_cnt == '0) begin
            next_conv_state = CV_IDLE;
            next_result = corrected;
            next_valid = 1'b1;
          end else begin
            next_conv_cnt = conv_cnt - 1'b1;
          end
        end
        default: begin
          next_conv_state = CV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_state <= CV_IDLE;
      conv_cnt <= '0;
      result <= RESULT_RESET;
      valid <= 1'b0;
    end else begin
      conv_state <= next_conv_state;
      conv_cnt <= next_conv_cnt;
      result <= next_result;
      valid <= next_valid;
    end
  end

  assign o_remote_result = result;
  assign o_result_valid = valid;
  assign o_conv_busy = conv_state == CV_RUN;

  // ==========================================================================
  // Checks
  localparam logic [11:0] MID_RAW = 12'h800;
  logic conv_done;
  assign conv_done = conv_state == CV_RUN && conv_cnt == '0 && !(req_event && req_kind == REQ_GCRESET);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_adj_write: assert property (req_event && req_kind == REQ_WRITE && pointer == ADJ_PTR
    |=> adj == $past(req_data)) else $error("adjustment write not stored");
  a_adj_readback: assert property (req_event && req_kind == REQ_READ && pointer == ADJ_PTR
    |=> rd_data == adj ##1 1) else $error("adjustment readback wrong");
  a_pos_adj_raise: assert property (conv_done && offset == OFFSET_RESET && !adj[7]
    |=> o_remote_result >= $past(i_remote_raw)) else $error("positive adjustment lowered result");
  a_neutral_adj: assert property (conv_done && offset == OFFSET_RESET && adj == ADJ_RESET
    |=> o_remote_result == $past(i_remote_raw) && o_result_valid) else $error("neutral result altered");
  a_neg_adj_lower: assert property (conv_done && offset == OFFSET_RESET && adj[7]
    |=> o_remote_result <= $past(i_remote_raw)) else $error("negative adjustment raised result");
  a_offset_added: assert property (conv_done && adj == ADJ_RESET && i_remote_raw == MID_RAW
    |=> o_remote_result == 12'(MID_RAW + {{4{$past(offset[7])}}, $past(offset), {FRAC_BITS{1'b0}}}))
    else $error("offset not added");
  a_gc_restores: assert property (req_event && req_kind == REQ_GCRESET
    |=> adj == ADJ_RESET && offset == OFFSET_RESET && pointer == PTR_RESET && o_soft_reset)
    else $error("software reset incomplete");
  a_gc_aborts: assert property (req_event && req_kind == REQ_GCRESET && o_conv_busy
    |=> !o_conv_busy && !o_result_valid ##1 !o_result_valid) else $error("conversion not aborted");
  a_no_stray_reset: assert property (!(req_event && req_kind == REQ_GCRESET)
    |=> !o_soft_reset) else $error("soft reset without command");
  a_id_readback: assert property (req_event && req_kind == REQ_READ && pointer == ID_PTR
    |=> rd_data == MAKER_ID) else $error("identification readback wrong");
  a_id_write_ignored: assert property (req_event && req_kind == REQ_WRITE && pointer == ID_PTR
    |=> $stable(adj) && $stable(offset)) else $error("identification write took effect");
  a_ack_returns: assert property ($changed(req_s2) |-> ##1 $changed(ack_toggle))
    else $error("request not acknowledged");
endmodule

// *** verilog/twowire_slave.sv ***
// Two-wire bus slave engine running on the link clock.
`timescale 1ns/100ps
module twowire_slave
  import cal_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic i_link_clk,
  input wire logic i_reset_n,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe,
  // Request handshake toward the core
  output logic o_req_toggle,
  output req_kind_e o_req_kind,
  output logic [7:0] o_req_data,
  input wire logic i_ack_toggle,
  input wire logic [7:0] i_rd_data
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WRITE,
                            ST_FETCH, ST_READ, ST_ACK_READ} state_e;

  // ==========================================================================
  // Pin and acknowledge synchronisers
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, ack_s1, ack_s2;

  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
      {ack_s1, ack_s2} <= 2'h0;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {i_scl, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {i_sda, sda_s1, sda_s2};
      {ack_s1, ack_s2} <= {i_ack_toggle, ack_s1};
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen, busy;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_seen = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign busy = o_req_toggle ^ ack_s2;

  // ==========================================================================
  // Byte engine
  state_e state, next_state;
  logic [7:0] shift, next_shift;
  logic [3:0] cnt, next_cnt;
  logic rw, next_rw, gc, next_gc, first, next_first, nack, next_nack;
  logic sda_oe, next_sda_oe, req_toggle, next_req_toggle;
  req_kind_e req_kind, next_req_kind;
  logic [7:0] req_data, next_req_data;

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_cnt = cnt;
    next_rw = rw;
    next_gc = gc;
    next_first = first;
    next_nack = nack;
    next_sda_oe = sda_oe;
    next_req_toggle = req_toggle;
    next_req_kind = req_kind;
    next_req_data = req_data;
    if (start_seen) begin
      next_state = ST_ADDR;
      next_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s2};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BITS_PER_BYTE) begin
            if (state == ST_WRITE) begin
              next_state = ST_ACK_WRITE;
              next_sda_oe = 1'b1;
              next_first = 1'b0;
              if (gc && first && shift == GC_RESET_CMD) begin
                next_req_kind = REQ_GCRESET;
                next_req_toggle = ~req_toggle;
              end else if (!gc) begin
                next_req_kind = first ? REQ_PTR : REQ_WRITE;
                next_req_data = shift;
                next_req_toggle = ~req_toggle;
              end
            end else if (shift[7:1] == DEV_ADDR || (shift[7:1] == GC_ADDR && !shift[0])) begin
              next_state = ST_ACK_ADDR;
              next_sda_oe = 1'b1;
              next_rw = shift[0];
              next_gc = shift[7:1] == GC_ADDR;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WRITE: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_cnt = 4'h0;
            if (state == ST_ACK_ADDR) begin
              next_first = 1'b1;
            end
            if (state == ST_ACK_ADDR && rw) begin
              next_state = ST_FETCH;
              next_req_kind = REQ_READ;
              next_req_toggle = ~req_toggle;
            end else begin
              next_state = ST_WRITE;
            end
          end
        end
        ST_FETCH: begin
          if (!busy) begin
            next_shift = i_rd_data;
            next_sda_oe = ~i_rd_data[7];
            next_cnt = 4'h1;
            next_state = ST_READ;
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (cnt == BITS_PER_BYTE) begin
              next_sda_oe = 1'b0;
              next_state = ST_ACK_READ;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_sda_oe = ~shift[6];
              next_cnt = cnt + 4'h1;
            end
          end
        end
        ST_ACK_READ: begin
          if (scl_rise) begin
            next_nack = sda_s2;
          end else if (scl_fall) begin
            if (nack) begin
              next_state = ST_IDLE;
            end else begin
              next_state = ST_FETCH;
              next_req_kind = REQ_READ;
              next_req_toggle = ~req_toggle;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      cnt <= 4'h0;
      rw <= 1'b0;
      gc <= 1'b0;
      first <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      req_toggle <= 1'b0;
      req_kind <= REQ_PTR;
      req_data <= 8'h00;
    end else begin
      state <= next_state;
      shift <= next_shift;
      cnt <= next_cnt;
      rw <= next_rw;
      gc <= next_gc;
      first <= next_first;
      nack <= next_nack;
      sda_oe <= next_sda_oe;
      req_toggle <= next_req_toggle;
      req_kind <= next_req_kind;
      req_data <= next_req_data;
    end
  end

  // Stretching the clock while the core works keeps every byte in step with it.
  // The stretch also covers the fetch cycle, so the first read bit is on the
  // wire no later than the clock is let go; otherwise a low bit would look like a start.
  assign o_scl_oe = busy | (state == ST_FETCH);
  assign o_sda_oe = sda_oe;
  assign o_req_toggle = req_toggle;
  assign o_req_kind = req_kind;
  assign o_req_data = req_data;
endmodule
